//--- shared/pfc_pkg.sv
// package for the parallel flash command port host controller
// assumes a 100 MHz system clock and a byte-wide flash device on pins
package pfc_pkg;
    // command bytes written in the first cycle
    localparam logic [7:0] CMD_READ       = 8'h00;
    localparam logic [7:0] CMD_PROGRAM    = 8'h40;
    localparam logic [7:0] CMD_PROG_VER   = 8'hC0;
    localparam logic [7:0] CMD_ERASE      = 8'h20;
    localparam logic [7:0] CMD_ERASE_VER  = 8'hA0;
    localparam logic [7:0] CMD_RESET      = 8'hFF;
    localparam logic [7:0] CMD_IDENT      = 8'h90;
    // identification addresses
    localparam logic [16:0] ID_MAKER_ADDR  = 17'h00000;
    localparam logic [16:0] ID_DEVICE_ADDR = 17'h00001;
    // programmable window; outside it every byte must stay erased-high
    localparam logic [16:0] PROG_LO       = 17'h01000;
    localparam logic [16:0] PROG_HI       = 17'h1EFFF;
    localparam logic [7:0]  BLANK_BYTE    = 8'hFF;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    // timing
    localparam int CLK_MHZ        = 100;
    localparam int PROG_TIME_US   = 10;
    localparam int ERASE_TIME_NS  = 9500000;
    localparam int PROG_CYC       = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYC      = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC     = 6;    // 60 ns write pulse
    localparam int ACCESS_CYC     = 16;   // 150 ns access, rounded up plus margin
    localparam int RECOVER_CYC    = 600;  // 6 us write recovery before read
    // host operations
    typedef enum logic [2:0] {
        PFC_OP_READ, PFC_OP_PROGRAM, PFC_OP_PROG_VER, PFC_OP_ERASE,
        PFC_OP_ERASE_VER, PFC_OP_ABORT, PFC_OP_IDENT
    } pfc_op_type;
endpackage

//--- src/pfc_timer.sv
// down-counting wait timer used for strobe widths and operation times
// assumes the same clock and synchronous reset as its parent
`timescale 1ns/1ns
`default_nettype none
module pfc_timer
#(
    parameter int WIDTH = 24
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // load and status
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output var  logic             done
);
    logic [WIDTH-1:0] cnt_reg;  // remaining cycles

    // count down to zero, reload on request
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cnt_reg <= '0;
        else if (load)
            cnt_reg <= count;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
    end

    // done looks at the count only: the parent reloads on done, so a
    // term in load here would close a combinational loop
    assign done = (cnt_reg == '0);
endmodule
`default_nettype wire

//--- src/pfc_host.sv
// host controller that drives a parallel flash command port over its pins
// assumes the device answers within the access time and times its own ops
// Function
// RULE_01 - low supply reads only, high enables commands
// RULE_02 - device drives byte when enabled and reading
// RULE_03 - output disable floats the data lines
// RULE_04 - chip disable means standby, lines float
// RULE_05 - write only at high level, oe high
// RULE_06 - read-only mode ignores all commands
// RULE_07 - write command byte, then second cycle
// RULE_08 - address at strobe fall, data at rise
// RULE_09 - read command persists across reads
// RULE_10 - command latch powers up as read
// RULE_11 - repeat non-read command byte each time
// RULE_12 - program: address and data, 10 us
// RULE_13 - one byte per program operation
// RULE_14 - program verify outputs last program address
// RULE_15 - verify after program, retry until match
// RULE_16 - erase needs two erase bytes, 9.5 ms
// RULE_17 - zero every location before erase
// RULE_18 - erase verify all addresses, retry
// RULE_19 - identification returns maker or device code
// RULE_20 - erase verify address with first cycle
// RULE_21 - two reset bytes cancel the command; abort writes three reset bytes (W1, W2, W3)
// RULE_22 - program only inside the allowed window
// RULE_23 - timed busy from cycle counter
`timescale 1ns/1ns
`default_nettype none
module pfc_host
    import pfc_pkg::*;
#(
    parameter int PROG_CYCLES  = PROG_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // user request
    input  wire logic        req_valid,
    input  wire pfc_op_type  req_op,
    input  wire logic [16:0] req_addr,
    input  wire logic [7:0]  req_data,
    output logic             req_ready,
    // user answer
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_match,
    output logic             rsp_refused,
    // device pins
    output logic             high_programming_level,
    output logic             chip_enable_n,
    output logic             output_enable_n,
    output logic             write_strobe_n,
    output logic [16:0]      address_lines,
    output logic [7:0]       data_lines_o,
    output logic             data_lines_oe,
    input  wire logic [7:0]  data_lines_i
);
    ////////////////////////////////////////////////////////////////////////
    // types and state
    typedef enum {
        ST_IDLE, ST_W1_LOW, ST_W1_HIGH, ST_W2_LOW, ST_W2_HIGH,
        ST_W3_LOW, ST_W3_HIGH, ST_BUSY, ST_RD_LOW, ST_DONE
    } pfc_state_type;

    pfc_state_type state_reg;     // sequencer state
    pfc_state_type prev_reg;      // state one edge ago, delays the strobe
    pfc_op_type    op_reg;        // operation in flight
    logic [16:0]   addr_reg;      // request address
    logic [7:0]    data_reg;      // request data
    logic [7:0]    cmd_reg;       // command byte of first cycle
    logic          refused;       // request that must not reach the device
    logic [7:0]    sync1_reg;     // first synchroniser stage
    logic [7:0]    sync2_reg;     // second synchroniser stage
    logic          tmr_load;      // timer reload strobe
    logic [23:0]   tmr_count;     // timer reload value
    logic          tmr_done;      // timer expired

    // command byte for each host operation
    function automatic logic [7:0] op_cmd(input pfc_op_type op);
        case (op)
            PFC_OP_PROGRAM:   op_cmd = CMD_PROGRAM;
            PFC_OP_PROG_VER:  op_cmd = CMD_PROG_VER;
            PFC_OP_ERASE:     op_cmd = CMD_ERASE;
            PFC_OP_ERASE_VER: op_cmd = CMD_ERASE_VER;
            PFC_OP_ABORT:     op_cmd = CMD_RESET;
            PFC_OP_IDENT:     op_cmd = CMD_IDENT;
            default:          op_cmd = CMD_READ;
        endcase
    endfunction

    // reads that produce data for the user
    function automatic logic op_reads(input pfc_op_type op);
        op_reads = (op == PFC_OP_READ) || (op == PFC_OP_PROG_VER)
                || (op == PFC_OP_ERASE_VER) || (op == PFC_OP_IDENT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // refusal: only a program request outside the window is refused
    always_comb
    begin
        refused = 1'b0;
        if (req_op == PFC_OP_PROGRAM && (req_addr < PROG_LO || req_addr > PROG_HI))
            refused = 1'b1;                                  // [RULE_22]
        // keep the blank area erased-high; zeroing allowed only in window
    end

    ////////////////////////////////////////////////////////////////////////
    // shared timer for strobe widths, access time and op durations
    pfc_timer #(.WIDTH(24)) u_timer
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (tmr_load),
        .count   (tmr_count),
        .done    (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // data lines pass two flip-flops before the answer register samples them
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end
        else
        begin
            sync1_reg <= data_lines_i;
            sync2_reg <= sync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer reload on the edge that enters a waiting state
    always_comb
    begin
        tmr_load  = 1'b0;
        tmr_count = 24'(STROBE_CYC);
        case (state_reg)
            ST_IDLE:
            begin
                // reads skip the command cycles and wait out the access time
                tmr_load = req_valid && !refused;
                if (req_op == PFC_OP_READ)
                    tmr_count = 24'(ACCESS_CYC);
            end
            ST_W1_LOW, ST_W2_LOW, ST_W3_LOW:
                tmr_load = tmr_done;
            ST_W1_HIGH:
            begin
                tmr_load = tmr_done;
                // verify and identification read next: write recovery first
                if (op_reads(op_reg))
                    tmr_count = 24'(RECOVER_CYC);
            end
            ST_W2_HIGH:
            begin
                tmr_load = tmr_done;
                if (op_reg == PFC_OP_PROGRAM)
                    tmr_count = 24'(PROG_CYCLES);            // [RULE_12] [RULE_23]
                else if (op_reg == PFC_OP_ERASE)
                    tmr_count = 24'(ERASE_CYCLES);           // [RULE_16] [RULE_23]
            end
            ST_W3_HIGH:
            begin
                tmr_load  = tmr_done;
                tmr_count = 24'(RECOVER_CYC);
            end
            ST_BUSY:
            begin
                tmr_load  = tmr_done && op_reads(op_reg);
                tmr_count = 24'(ACCESS_CYC);
            end
            default:
                tmr_load = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: first cycle command, second cycle operand, optional third
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            op_reg    <= PFC_OP_READ;
            addr_reg  <= 17'h00000;
            data_reg  <= 8'h00;
            cmd_reg   <= CMD_READ;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (req_valid && !refused)
                    begin
                        op_reg   <= req_op;
                        addr_reg <= req_addr;
                        data_reg <= req_data;
                        cmd_reg  <= op_cmd(req_op);
                        // reads go direct: device latch powers up as read
                        // and stays there; no command byte needed [RULE_09] [RULE_10]
                        if (req_op == PFC_OP_READ)
                            state_reg <= ST_BUSY;
                        else
                            state_reg <= ST_W1_LOW;                  // [RULE_11]
                    end
                ST_W1_LOW:  if (tmr_done) state_reg <= ST_W1_HIGH;   // [RULE_07]
                ST_W1_HIGH:
                    if (tmr_done)
                        state_reg <= (op_reg == PFC_OP_ERASE_VER
                                   || op_reg == PFC_OP_PROG_VER
                                   || op_reg == PFC_OP_IDENT) ? ST_BUSY : ST_W2_LOW;
                ST_W2_LOW:  if (tmr_done) state_reg <= ST_W2_HIGH;
                ST_W2_HIGH:
                    if (tmr_done)
                        state_reg <= (op_reg == PFC_OP_ABORT) ? ST_W3_LOW : ST_BUSY;
                ST_W3_LOW:  if (tmr_done) state_reg <= ST_W3_HIGH;   // [RULE_21]
                ST_W3_HIGH: if (tmr_done) state_reg <= ST_BUSY;
                ST_BUSY:
                    if (tmr_done)
                        state_reg <= op_reads(op_reg) ? ST_RD_LOW : ST_DONE;
                ST_RD_LOW:  if (tmr_done) state_reg <= ST_DONE;
                ST_DONE:    state_reg <= ST_IDLE;
                default:    state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive; every pin is a flip-flop so the device sees clean levels
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prev_reg               <= ST_IDLE;
            high_programming_level <= 1'b0;  // read-only until a write [RULE_01]
            chip_enable_n          <= 1'b1;  // standby, lines float [RULE_04]
            output_enable_n        <= 1'b1;
            write_strobe_n         <= 1'b1;
            address_lines          <= 17'h00000;
            data_lines_o           <= 8'h00;
            data_lines_oe          <= 1'b0;
        end
        else
        begin
            prev_reg               <= state_reg;
            // supply raised for any operation that writes a command [RULE_06]
            high_programming_level <= (state_reg != ST_IDLE) && (op_reg != PFC_OP_READ);
            chip_enable_n          <= (state_reg == ST_IDLE) || (state_reg == ST_DONE);
            // strobe falls one edge after address, data and supply settle,
            // so the device never latches a changing bus [RULE_05]
            write_strobe_n  <= !((state_reg == ST_W1_LOW || state_reg == ST_W2_LOW
                              || state_reg == ST_W3_LOW) && state_reg == prev_reg);
            output_enable_n <= !(state_reg == ST_RD_LOW);    // [RULE_02]
            // host drives data only through write phases [RULE_03]
            data_lines_oe   <= (state_reg >= ST_W1_LOW) && (state_reg <= ST_W3_HIGH);
            // address held across strobe fall; data held across rise [RULE_08]
            case (state_reg)
                ST_W1_LOW, ST_W1_HIGH:
                begin
                    address_lines <= addr_reg;               // [RULE_20]
                    data_lines_o  <= cmd_reg;
                end
                ST_W2_LOW, ST_W2_HIGH, ST_W3_LOW, ST_W3_HIGH:
                begin
                    address_lines <= addr_reg;               // [RULE_12] [RULE_13]
                    if (op_reg == PFC_OP_PROGRAM)
                        data_lines_o <= data_reg;
                    else
                        data_lines_o <= cmd_reg;             // [RULE_16] [RULE_21]
                end
                default:
                begin
                    // identification picks maker or device by address [RULE_19]
                    address_lines <= addr_reg;
                    data_lines_o  <= data_lines_o;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // user handshake and answer
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            req_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_data    <= 8'h00;
            rsp_match   <= 1'b0;
            rsp_refused <= 1'b0;
        end
        else
        begin
            req_ready   <= (state_reg == ST_IDLE) && !(req_valid);
            rsp_valid   <= (state_reg == ST_DONE)
                        || (state_reg == ST_IDLE && req_valid && refused);
            rsp_refused <= (state_reg == ST_IDLE) && req_valid && refused;
            if (state_reg == ST_RD_LOW && tmr_done)
            begin
                rsp_data <= sync2_reg;
                // verify compares: program vs data, erase vs blank [RULE_14] [RULE_15] [RULE_18]
                if (op_reg == PFC_OP_ERASE_VER)
                    rsp_match <= (sync2_reg == BLANK_BYTE);
                else
                    rsp_match <= (sync2_reg == data_reg);
            end
        end
    end
    // retry loops and pre-erase zeroing stay with the user [RULE_17]
endmodule
`default_nettype wire

//--- bench/pfc_host_sva.sv
// checker for the host controller pins and answer handshake
// assumes requests are raised only while the controller is idle
`timescale 1ns/1ns
`default_nettype none
module pfc_host_chk
    import pfc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // user side
    input  wire logic        req_valid,
    input  wire pfc_op_type  req_op,
    input  wire logic [16:0] req_addr,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_refused,
    // device pins
    input  wire logic        high_programming_level,
    input  wire logic        chip_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_strobe_n,
    input  wire logic [16:0] address_lines,
    input  wire logic [7:0]  data_lines_o,
    input  wire logic        data_lines_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // strobe phases last at least six cycles each, so the device sees a full pulse
    sequence s_strobe_low;
        !write_strobe_n [*6];
    endsequence
    sequence s_strobe_high;
        write_strobe_n [*6];
    endsequence
    property p_write_cond;
        $fell(write_strobe_n) |-> !chip_enable_n && output_enable_n && high_programming_level;
    endproperty
    property p_read_ce;
        $fell(output_enable_n) |-> !chip_enable_n && write_strobe_n;
    endproperty
    property p_no_contend;
        !output_enable_n |-> !data_lines_oe;
    endproperty
    property p_strobe_width;
        $fell(write_strobe_n) |-> s_strobe_low;
    endproperty
    property p_strobe_gap;
        $rose(write_strobe_n) |-> s_strobe_high;
    endproperty
    // the address must hold while the strobe is low, it is taken at the fall
    property p_addr_hold;
        !write_strobe_n && !$past(write_strobe_n) |-> $stable(address_lines);
    endproperty
    property p_data_hold;
        !write_strobe_n |-> data_lines_oe && $stable(data_lines_o);
    endproperty
    property p_refuse;
        $rose(req_valid) && req_op == PFC_OP_PROGRAM && (req_addr < PROG_LO || req_addr > PROG_HI)
            |=> rsp_valid && rsp_refused && chip_enable_n;
    endproperty
    property p_rsp_pulse;
        rsp_valid |=> !rsp_valid;
    endproperty
    ////////////////////////////////////////////////////////////////////////////
    a_write_cond: assert property (p_write_cond) else $error("write strobe outside write state");
    a_read_ce: assert property (p_read_ce) else $error("read without chip enable");
    a_no_contend: assert property (p_no_contend) else $error("host drives during read");
    a_strobe_width: assert property (p_strobe_width) else $error("write pulse too short");
    a_strobe_gap: assert property (p_strobe_gap) else $error("strobe gap too short");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
    a_data_hold: assert property (p_data_hold) else $error("data moved in strobe");
    a_refuse: assert property (p_refuse) else $error("window miss not refused");
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer longer than a cycle");
endmodule
bind pfc_host pfc_host_chk u_chk (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused),
    .high_programming_level(high_programming_level), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .address_lines(address_lines), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));
`default_nettype wire

//--- bench/pfc_flash_model.sv
// behavioural model of the flash device on its parallel pins
// assumes pins come from registers; operation times are not modelled
`timescale 1ns/1ns
`default_nettype none
module pfc_flash_model
#(
    parameter logic [7:0] MAKER_CODE  = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3C  // arbitrary value
)
(
    // pins from the host
    input  wire logic        supply_hi,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  din,
    // data driven back
    output var  logic [7:0]  dout,
    output var  logic        dout_en
);
    logic [7:0]  mem [0:131071];      // whole array, starts erased
    logic [7:0]  cmd_reg   = 8'h00;
    logic [16:0] lat_addr  = '0;      // address taken at strobe fall
    logic [16:0] prog_addr = '0;      // last program address
    logic [16:0] ev_addr   = '0;      // erase verify address
    logic        second    = 1'b0;    // a data write is awaited
    function automatic logic [7:0] rd(input logic [16:0] a);
        return mem[a];
    endfunction
    // the array starts out erased
    initial
        for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
    ////////////////////////////////////////////////////////////////////////////
    // write cycles only count in the write state at the high level
    always @(negedge we_n)
        if (!ce_n && oe_n && supply_hi) lat_addr = addr;
    always @(posedge we_n)
    begin
        if (!ce_n && oe_n && supply_hi)
        begin
            if (din === 8'hFF)
            begin
                cmd_reg = 8'h00;
                second  = 1'b0;
            end
            else if (second)
            begin
                // programming can only clear bits, as a real array does
                if (cmd_reg == 8'h40)
                begin
                    mem[lat_addr] = rd(lat_addr) & din;
                    prog_addr     = lat_addr;
                end
                if (cmd_reg == 8'h20 && din == 8'h20)
                    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
                cmd_reg = 8'h00;
                second  = 1'b0;
            end
            else
            begin
                cmd_reg = din;
                if (din == 8'hA0) ev_addr = lat_addr;
                second = (din == 8'h40 || din == 8'h20);
            end
        end
    end
    // one-shot read commands fall back to read mode after their cycle
    always @(posedge oe_n)
        if (cmd_reg != 8'h40 && cmd_reg != 8'h20) cmd_reg = 8'h00;
    always_comb
    begin
        dout_en = !ce_n && !oe_n && we_n;
        case (cmd_reg)
            8'hC0:   dout = rd(prog_addr);
            8'hA0:   dout = rd(ev_addr);
            8'h90:   dout = (addr == 17'h0) ? MAKER_CODE : (addr == 17'h1) ? DEVICE_CODE : 8'hFF;
            default: dout = rd(addr);
        endcase
    end
endmodule
`default_nettype wire

//--- bench/tb_parallel_flash_command_port.sv
// self-checking bench: host controller against the flash model
// assumes shortened program and erase counts of 20 and 50 cycles
`timescale 1ns/1ns
`default_nettype none
module tb_parallel_flash_command_port;
    import pfc_pkg::*;
    localparam logic [7:0] MAKER  = 8'h5A; // arbitrary value
    localparam logic [7:0] DEVICE = 8'h3C; // arbitrary value
    logic        clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
    pfc_op_type  req_op = PFC_OP_READ;
    logic [16:0] req_addr = '0, addr;
    logic [7:0]  req_data = '0, rsp_data, host_d, dev_d, bus, flt = 8'h00;
    logic        req_ready, rsp_valid, rsp_match, rsp_refused;
    logic        vpp, ce_n, oe_n, we_n, host_oe, dev_en;
    int          n_errors = 0, n_compared = 0;
    always #5 clk = ~clk;
    // a released bus shows the inverse of its last level, never stale data
    assign bus = host_oe ? host_d : dev_en ? dev_d : flt;
    always @(posedge clk)
        if (!sys_rst) flt <= ~bus;
    pfc_host #(.PROG_CYCLES(20), .ERASE_CYCLES(50)) dut (.clk(clk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_match(rsp_match), .rsp_refused(rsp_refused), .high_programming_level(vpp),
        .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_strobe_n(we_n),
        .address_lines(addr), .data_lines_o(host_d), .data_lines_oe(host_oe),
        .data_lines_i(bus));
    pfc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash (.supply_hi(vpp),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .din(bus), .dout(dev_d),
        .dout_en(dev_en));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one request while idle, then a bounded wait for the answer pulse
    task automatic run_op(input pfc_op_type op, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        #1;
        req_op    = op;
        req_addr  = a;
        req_data  = d;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        if (n == 3000)
        begin
            n_errors++;
            $display("BAD %0t no answer", $time);
        end
    endtask
    task automatic s_read_reset();
        check({7'h00, req_ready}, 8'h01);
        run_op(PFC_OP_READ, 17'h01234, 8'h00);
        check(rsp_data, 8'hFF);
    endtask
    task automatic s_program();
        run_op(PFC_OP_PROGRAM, PROG_LO, 8'hA5);
        check({7'h00, rsp_refused}, 8'h00);
        run_op(PFC_OP_PROG_VER, 17'h1ABCD, 8'hA5);
        check(rsp_data, 8'hA5);
        check({7'h00, rsp_match}, 8'h01);
        run_op(PFC_OP_READ, PROG_LO + 17'h1, 8'h00);
        check(rsp_data, 8'hFF);
        run_op(PFC_OP_READ, PROG_LO, 8'h00);
        check(rsp_data, 8'hA5);
        run_op(PFC_OP_PROGRAM, PROG_HI, 8'h3C);
        run_op(PFC_OP_READ, PROG_HI, 8'h00);
        check(rsp_data, 8'h3C);
    endtask
    task automatic s_refused();
        run_op(PFC_OP_PROGRAM, PROG_LO - 17'h1, 8'h00);
        check({7'h00, rsp_refused}, 8'h01);
        run_op(PFC_OP_PROGRAM, PROG_HI + 17'h1, 8'h00);
        check({7'h00, rsp_refused}, 8'h01);
        run_op(PFC_OP_READ, PROG_HI + 17'h1, 8'h00);
        check(rsp_data, 8'hFF);
    endtask
    task automatic s_ident();
        run_op(PFC_OP_IDENT, ID_MAKER_ADDR, 8'h00);
        check(rsp_data, MAKER);
        run_op(PFC_OP_IDENT, ID_DEVICE_ADDR, 8'h00);
        check(rsp_data, DEVICE);
    endtask
    // abort after a completed program; the target byte must keep its programmed value
    task automatic s_abort();
        run_op(PFC_OP_PROGRAM, PROG_LO + 17'h2, 8'h0F);
        run_op(PFC_OP_ABORT, PROG_LO + 17'h2, 8'h00);
        run_op(PFC_OP_READ, PROG_LO + 17'h2, 8'h00);
        check(rsp_data, 8'h0F);
    endtask
    task automatic s_erase();
        run_op(PFC_OP_PROGRAM, PROG_LO, 8'h00);
        run_op(PFC_OP_PROGRAM, PROG_LO + 17'h2, 8'h00);
        run_op(PFC_OP_PROGRAM, PROG_HI, 8'h00);
        run_op(PFC_OP_ERASE, 17'h00000, 8'h00);
        run_op(PFC_OP_ERASE_VER, PROG_LO, 8'h00);
        check(rsp_data, 8'hFF);
        check({7'h00, rsp_match}, 8'h01);
        run_op(PFC_OP_ERASE_VER, PROG_HI, 8'h00);
        check(rsp_data, 8'hFF);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_errors++;
        test_done();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        s_read_reset();
        s_program();
        s_refused();
        s_ident();
        s_abort();
        s_erase();
        test_done();
    end
endmodule
`default_nettype wire
